// ===== rtl/pin_power_pkg.sv
// Package: register map, field layout, timing and state types of the pin/power block
package pin_power_pkg;
  localparam int NPORT = 2;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LINE0 = 8'h04;
  localparam logic [7:0] ADDR_LINE1 = 8'h08;
  localparam logic [7:0] ADDR_TX0 = 8'h0c;
  localparam logic [7:0] ADDR_TX1 = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  // Control field positions
  localparam int CTRL_AUX = 0;
  localparam int CTRL_DTR = 1;
  localparam int CTRL_RTS = 3;
  // Line field: [1:0] length code (5..8 bits), [4:2] parity
  localparam int LINE_LEN = 0;
  localparam int LINE_PAR = 2;
  localparam logic [4:0] LINE_RST = 5'h03;
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_EVEN = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;
  // Status field positions
  localparam int STAT_MDM0 = 0;
  localparam int STAT_MDM1 = 4;
  localparam int STAT_BUSY = 8;
  localparam int STAT_P0HALF = 10;
  localparam int STAT_P1HALF = 11;
  localparam int STAT_P1DSR = 12;
  localparam int STAT_CFG = 13;
  localparam int STAT_SUSP = 14;
  localparam int STAT_VBUS = 15;
  localparam int STAT_HOLD = 16;
  localparam int STAT_DISCH = 17;
  // Timing
  localparam int CLK_HZ = 250_000_000;
  localparam int RESET_DELAY_MS = 15;
  localparam int RESET_DELAY_CYC = (CLK_HZ / 1000) * RESET_DELAY_MS;
  localparam logic [15:0] BAUD_DIV_DEF = 16'h00d9;

  typedef enum logic [1:0] {PWR_HOLD, PWR_ACTIVE, PWR_SUSPEND} pwr_state_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_type;

  typedef struct packed {
    pwr_state_type pwr;
    logic [21:0] hold_cnt;
    logic p0_half;
    logic p1_half;
    logic p1_on_dsr;
    logic cfg;
    logic aux;
    logic discharge;
    logic [1:0] dtr;
    logic [1:0] rts;
    logic [1:0][4:0] line;
    logic [1:0][11:0] sh;
    logic [1:0][3:0] bits_left;
    logic [1:0][15:0] baud;
    logic ack;
    logic [31:0] rdat;
  } state_type;
endpackage

// ===== rtl/pin_power_ctrl.sv
// Pin function, strap, serial transmit and USB power state control with a Wishbone slave
//
// Functional notes
// RULE1: transmit lines idle high
// RULE2: modem inputs asserted when low
// RULE3: RTS/DTR driven low when asserted
// RULE4: port0 DTR strap low selects tx indicator
// RULE5: tx indicator high while port sends
// RULE6: port1 strap, DSR low: DSR indicates
// RULE7: port1 strap, DSR high: DTR indicates
// RULE8: configured output low, inactive in suspend
// RULE9: enter suspend on bus request
// RULE10: lost bus power shuts USB, suspends
// RULE11: no detect input means power present
// RULE12: aux bit set disables pull-down
// RULE13: low IO supply sinks, then re-enables
// RULE14: external reset low resets the device
// RULE15: 5 to 8 bits, five parity modes
// RULE16: straps sampled after every reset
// RULE17: wait delay after reset release
// RULE18: strap choice latched until reset
// RULE19: replaced modem function reads inactive
`timescale 1ns/10ps
module pin_power_ctrl #(
  parameter logic [21:0] RESET_DELAY = 22'(pin_power_pkg::RESET_DELAY_CYC),
  parameter logic [15:0] BAUD_DIV = pin_power_pkg::BAUD_DIV_DEF,
  parameter bit HAS_VBUS = 1'b1
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_reset_n_i,
  // Register bus
  input wire pin_power_pkg::wb_req_type wb_i,
  output pin_power_pkg::wb_rsp_type wb_o,
  // Serial data and modem pins
  output logic serial_out_port0_o,
  output logic serial_out_port1_o,
  output logic [1:0] rts_n_o,
  input wire logic [1:0] cts_n_i,
  input wire logic [1:0] ri_n_i,
  input wire logic [1:0] dcd_n_i,
  input wire logic dsr0_n_i,
  // Strap-capable pins
  input wire logic dtr0_pin_i,
  output logic dtr0_pin_o,
  output logic dtr0_pin_oe_o,
  input wire logic dtr1_pin_i,
  output logic dtr1_pin_o,
  output logic dtr1_pin_oe_o,
  input wire logic dsr1_pin_i,
  output logic dsr1_pin_o,
  output logic dsr1_pin_oe_o,
  // USB engine and power
  input wire logic vbus_i,
  input wire logic usb_suspend_req_i,
  input wire logic usb_config_done_i,
  input wire logic io_supply_low_i,
  output logic usb_configured_n_o,
  output logic usb_suspend_o,
  output logic usb_phy_off_o,
  output logic vbus_pulldown_en_o,
  output logic vbus_discharge_o
);
  pin_power_pkg::state_type st_ff;
  pin_power_pkg::state_type nxt_st;
  logic rst_all;
  logic vbus_ok;
  logic req;
  logic [1:0] busy;
  logic [1:0] dtr_view;
  logic dsr1_asserted;
  logic tx_port;
  logic [15:0] frame_v;
  logic [31:0] rd_word;

  // Frame builder: {bit count, bits lsb first}; start, data, parity, stop
  function automatic logic [15:0] build_frame(input logic [7:0] d, input logic [4:0] ln);
    logic [11:0] f;
    logic [3:0] len;
    logic [7:0] md;
    logic par_on;
    logic par_bit;
    logic [2:0] pm;
    f = '1;
    len = 4'h5 + {2'h0, ln[pin_power_pkg::LINE_LEN +: 2]};
    pm = ln[pin_power_pkg::LINE_PAR +: 3];
    md = d & (8'hff >> (4'h8 - len));
    par_on = (pm != pin_power_pkg::PAR_NONE);
    case (pm)
      pin_power_pkg::PAR_ODD: par_bit = ~^md;
      pin_power_pkg::PAR_EVEN: par_bit = ^md;
      pin_power_pkg::PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (4'(i) < len)
        f[i + 1] = md[i];
    end
    if (par_on)
      f[len + 4'h1] = par_bit;
    return {len + 4'h2 + {3'h0, par_on}, f}; // RULE15
  endfunction

  // Either reset input resets all state: shifters to ones, line fields to LINE_RST, the rest to zero
  assign rst_all = rst_i | ~ext_reset_n_i; // RULE14
  // Variants without a detect input see permanent bus power
  assign vbus_ok = HAS_VBUS ? vbus_i : 1'b1; // RULE11
  assign req = wb_i.cyc && wb_i.stb && !st_ff.ack;
  assign busy = {st_ff.bits_left[1] != 4'h0, st_ff.bits_left[0] != 4'h0};
  // Reassigned DTR reads inactive to software
  assign dtr_view = st_ff.dtr & ~{st_ff.p1_half & ~st_ff.p1_on_dsr, st_ff.p0_half}; // RULE19
  assign dsr1_asserted = ~dsr1_pin_i & ~(st_ff.p1_half & st_ff.p1_on_dsr); // RULE2 RULE19
  assign tx_port = (wb_i.adr == pin_power_pkg::ADDR_TX1);
  assign frame_v = build_frame(wb_i.dat[7:0], st_ff.line[tx_port]);

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_word = '0;
    case (wb_i.adr)
      pin_power_pkg::ADDR_CTRL:
      begin
        rd_word[pin_power_pkg::CTRL_AUX] = st_ff.aux;
        rd_word[pin_power_pkg::CTRL_DTR +: 2] = dtr_view;
        rd_word[pin_power_pkg::CTRL_RTS +: 2] = st_ff.rts;
      end
      pin_power_pkg::ADDR_LINE0: rd_word[4:0] = st_ff.line[0];
      pin_power_pkg::ADDR_LINE1: rd_word[4:0] = st_ff.line[1];
      pin_power_pkg::ADDR_STAT:
      begin
        rd_word[pin_power_pkg::STAT_MDM0 +: 4] = ~{dcd_n_i[0], ri_n_i[0], dsr0_n_i, cts_n_i[0]}; // RULE2
        rd_word[pin_power_pkg::STAT_MDM1 +: 4] = {~dcd_n_i[1], ~ri_n_i[1], dsr1_asserted, ~cts_n_i[1]}; // RULE2
        rd_word[pin_power_pkg::STAT_BUSY +: 2] = busy;
        rd_word[pin_power_pkg::STAT_P0HALF] = st_ff.p0_half;
        rd_word[pin_power_pkg::STAT_P1HALF] = st_ff.p1_half;
        rd_word[pin_power_pkg::STAT_P1DSR] = st_ff.p1_on_dsr;
        rd_word[pin_power_pkg::STAT_CFG] = st_ff.cfg;
        rd_word[pin_power_pkg::STAT_SUSP] = (st_ff.pwr == pin_power_pkg::PWR_SUSPEND);
        rd_word[pin_power_pkg::STAT_VBUS] = vbus_ok;
        rd_word[pin_power_pkg::STAT_HOLD] = (st_ff.pwr == pin_power_pkg::PWR_HOLD);
        rd_word[pin_power_pkg::STAT_DISCH] = st_ff.discharge;
      end
      default: rd_word = '0;
    endcase
  end

  // Next state of the whole block
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.cfg = usb_config_done_i & vbus_ok;
    // Power sequence; straps are sampled while the pins are not driven
    case (st_ff.pwr)
      pin_power_pkg::PWR_HOLD:
      begin
        nxt_st.p0_half = ~dtr0_pin_i; // RULE4 RULE16 RULE18
        nxt_st.p1_half = ~dtr1_pin_i; // RULE16
        nxt_st.p1_on_dsr = ~dsr1_pin_i; // RULE6 RULE7
        if (st_ff.hold_cnt >= RESET_DELAY - 22'h1)
          nxt_st.pwr = vbus_ok ? pin_power_pkg::PWR_ACTIVE : pin_power_pkg::PWR_SUSPEND;
        else
          nxt_st.hold_cnt = st_ff.hold_cnt + 22'h1; // RULE17
      end
      pin_power_pkg::PWR_ACTIVE:
      begin
        if (!vbus_ok || usb_suspend_req_i)
          nxt_st.pwr = pin_power_pkg::PWR_SUSPEND; // RULE9 RULE10
      end
      pin_power_pkg::PWR_SUSPEND:
      begin
        if (vbus_ok && !usb_suspend_req_i)
          nxt_st.pwr = pin_power_pkg::PWR_ACTIVE;
      end
      default: nxt_st.pwr = pin_power_pkg::PWR_HOLD;
    endcase
    // Discharge only while the pull-down is off; recovery turns it back on
    if (!st_ff.aux)
      nxt_st.discharge = 1'b0;
    else if (io_supply_low_i)
      nxt_st.discharge = 1'b1; // RULE13
    else if (st_ff.discharge)
    begin
      nxt_st.discharge = 1'b0;
      nxt_st.aux = 1'b0; // RULE13
    end
    // Bit timing; shifting fills with ones so the line rests high
    for (int p = 0; p < pin_power_pkg::NPORT; p++)
    begin
      if (st_ff.bits_left[p] != 4'h0)
      begin
        if (st_ff.baud[p] == 16'h0)
        begin
          nxt_st.sh[p] = {1'b1, st_ff.sh[p][11:1]}; // RULE1
          nxt_st.bits_left[p] = st_ff.bits_left[p] - 4'h1;
          nxt_st.baud[p] = BAUD_DIV - 16'h1;
        end
        else
          nxt_st.baud[p] = st_ff.baud[p] - 16'h1;
      end
    end
    // Bus access last, so a software write wins over a hardware clear
    if (req)
    begin
      nxt_st.ack = 1'b1;
      nxt_st.rdat = rd_word;
      if (wb_i.we && wb_i.sel[0])
      begin
        case (wb_i.adr)
          pin_power_pkg::ADDR_CTRL:
          begin
            nxt_st.aux = wb_i.dat[pin_power_pkg::CTRL_AUX]; // RULE12
            nxt_st.dtr = wb_i.dat[pin_power_pkg::CTRL_DTR +: 2];
            nxt_st.rts = wb_i.dat[pin_power_pkg::CTRL_RTS +: 2];
          end
          pin_power_pkg::ADDR_LINE0: nxt_st.line[0] = wb_i.dat[4:0];
          pin_power_pkg::ADDR_LINE1: nxt_st.line[1] = wb_i.dat[4:0];
          pin_power_pkg::ADDR_TX0, pin_power_pkg::ADDR_TX1:
          begin
            // A write to a busy or suspended port is dropped
            if (!busy[tx_port] && st_ff.pwr == pin_power_pkg::PWR_ACTIVE)
            begin
              nxt_st.bits_left[tx_port] = frame_v[15:12]; // RULE15
              nxt_st.sh[tx_port] = frame_v[11:0];
              nxt_st.baud[tx_port] = BAUD_DIV - 16'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_all)
      st_ff <= '{pwr: pin_power_pkg::PWR_HOLD, sh: '1,
                 line: {pin_power_pkg::LINE_RST, pin_power_pkg::LINE_RST}, default: '0};
    else
      st_ff <= nxt_st;
  end

  // Pin and status outputs
  assign wb_o = '{ack: st_ff.ack, dat: st_ff.rdat};
  assign serial_out_port0_o = st_ff.sh[0][0]; // RULE1
  assign serial_out_port1_o = st_ff.sh[1][0]; // RULE1
  assign rts_n_o = ~st_ff.rts; // RULE3
  assign dtr0_pin_oe_o = (st_ff.pwr != pin_power_pkg::PWR_HOLD);
  assign dtr0_pin_o = st_ff.p0_half ? busy[0] : ~st_ff.dtr[0]; // RULE3 RULE4 RULE5
  assign dtr1_pin_oe_o = (st_ff.pwr != pin_power_pkg::PWR_HOLD);
  assign dtr1_pin_o = (st_ff.p1_half && !st_ff.p1_on_dsr) ? busy[1] : ~st_ff.dtr[1]; // RULE7
  assign dsr1_pin_oe_o = dtr1_pin_oe_o && st_ff.p1_half && st_ff.p1_on_dsr; // RULE6
  assign dsr1_pin_o = busy[1]; // RULE5
  assign usb_configured_n_o = ~(st_ff.cfg && st_ff.pwr == pin_power_pkg::PWR_ACTIVE); // RULE8
  assign usb_suspend_o = (st_ff.pwr == pin_power_pkg::PWR_SUSPEND);
  assign usb_phy_off_o = ~vbus_ok; // RULE10
  assign vbus_pulldown_en_o = ~st_ff.aux; // RULE12
  assign vbus_discharge_o = st_ff.discharge;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_all);

  property p_tx_idle;
    busy[0] == 1'b0 |-> serial_out_port0_o == 1'b1;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("idle tx line not high"); // RULE1
  property p_cts_read;
    wb_o.ack && !wb_i.we && wb_i.adr == pin_power_pkg::ADDR_STAT |-> wb_o.dat[0] == !$past(cts_n_i[0]);
  endproperty
  a_cts_read: assert property (p_cts_read) else $error("cts status not active low"); // RULE2
  property p_rts_write;
    wb_o.ack && wb_i.we && wb_i.sel[0] && wb_i.adr == pin_power_pkg::ADDR_CTRL
      |-> rts_n_o[0] == !wb_i.dat[pin_power_pkg::CTRL_RTS];
  endproperty
  a_rts_write: assert property (p_rts_write) else $error("rts pin level wrong after write"); // RULE3
  property p_tx_active_port0;
    st_ff.pwr != pin_power_pkg::PWR_HOLD && st_ff.p0_half |-> dtr0_pin_oe_o && dtr0_pin_o == busy[0];
  endproperty
  a_tx_active_port0: assert property (p_tx_active_port0) else $error("port0 tx indicator wrong"); // RULE4 RULE5
  property p_dsr1_ind;
    st_ff.pwr != pin_power_pkg::PWR_HOLD && st_ff.p1_half && st_ff.p1_on_dsr
      |-> dsr1_pin_oe_o && dsr1_pin_o == busy[1] && dtr1_pin_o == !st_ff.dtr[1];
  endproperty
  a_dsr1_ind: assert property (p_dsr1_ind) else $error("dsr1 indicator wrong"); // RULE6
  property p_dtr1_ind;
    st_ff.pwr != pin_power_pkg::PWR_HOLD && st_ff.p1_half && !st_ff.p1_on_dsr
      |-> !dsr1_pin_oe_o && dtr1_pin_o == busy[1];
  endproperty
  a_dtr1_ind: assert property (p_dtr1_ind) else $error("dtr1 indicator wrong"); // RULE7
  property p_cfg_susp;
    usb_suspend_o |-> usb_configured_n_o;
  endproperty
  a_cfg_susp: assert property (p_cfg_susp) else $error("configured active in suspend"); // RULE8
  property p_susp_req;
    st_ff.pwr == pin_power_pkg::PWR_ACTIVE && (usb_suspend_req_i || !vbus_ok) |=> usb_suspend_o;
  endproperty
  a_susp_req: assert property (p_susp_req) else $error("suspend not entered"); // RULE9 RULE10
  property p_pulldown;
    st_ff.discharge && !io_supply_low_i && !(req && wb_i.we && wb_i.adr == pin_power_pkg::ADDR_CTRL)
      |=> vbus_pulldown_en_o && !vbus_discharge_o;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down not restored"); // RULE12 RULE13
  property p_hold;
    st_ff.pwr == pin_power_pkg::PWR_HOLD && st_ff.hold_cnt < RESET_DELAY - 22'h1
      |=> st_ff.pwr == pin_power_pkg::PWR_HOLD && st_ff.hold_cnt == $past(st_ff.hold_cnt) + 22'h1;
  endproperty
  a_hold: assert property (p_hold) else $error("reset delay cut short"); // RULE17
  property p_strap_kept;
    $past(st_ff.pwr) != pin_power_pkg::PWR_HOLD
      |-> $stable(st_ff.p0_half) && $stable(st_ff.p1_half) && $stable(st_ff.p1_on_dsr);
  endproperty
  a_strap_kept: assert property (p_strap_kept) else $error("strap choice changed"); // RULE18
  property p_dtr_hide;
    st_ff.p0_half && wb_o.ack && !wb_i.we && wb_i.adr == pin_power_pkg::ADDR_CTRL
      |-> !wb_o.dat[pin_power_pkg::CTRL_DTR];
  endproperty
  a_dtr_hide: assert property (p_dtr_hide) else $error("replaced dtr reads active"); // RULE19

  c_tx_start: cover property (!busy[0] ##1 busy[0]);
  c_suspend: cover property (st_ff.pwr == pin_power_pkg::PWR_ACTIVE ##1 usb_suspend_o);
  c_discharge: cover property (vbus_discharge_o ##1 !vbus_discharge_o);
  c_dsr1_mode: cover property (dsr1_pin_oe_o && busy[1]);
endmodule

// ===== tb/serial_peer.sv
// Pin-side peer: strap resistors and resolved levels of the shared modem pins
`timescale 1ns/10ps
module serial_peer (
  // Strap fitting, high = external pull-down present
  input wire logic [2:0] pd_i,
  // Device drive of dtr0, dtr1, dsr1
  input wire logic [2:0] pin_o_i,
  input wire logic [2:0] pin_oe_i,
  // Resolved wire levels
  output logic [2:0] lvl_o
);
  // Undriven pin settles to its pull, never to the last driven value
  assign lvl_o[0] = pin_oe_i[0] ? pin_o_i[0] : ~pd_i[0];
  assign lvl_o[1] = pin_oe_i[1] ? pin_o_i[1] : ~pd_i[1];
  assign lvl_o[2] = pin_oe_i[2] ? pin_o_i[2] : ~pd_i[2];
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the pin and power control block
`timescale 1ns/10ps
module testbench;
  localparam int DLY = 20;
  localparam int BD = 4;
  logic clk_i, rst_i, ext_reset_n_i;
  pin_power_pkg::wb_req_type wb_i;
  pin_power_pkg::wb_rsp_type wb_o;
  logic tx0, tx1, dsr0_n, vbus, sreq, cdone, io_low;
  logic cfg_n, susp, phy_off, pd_en, disch;
  logic cfg_n_nv, susp_nv, phy_off_nv;
  logic [1:0] rts_n, cts_n, ri_n, dcd_n;
  logic [2:0] pin_o, pin_oe, lvl, pd;
  logic [31:0] rd;
  int num_errors, checked;

  pin_power_ctrl #(.RESET_DELAY(22'(DLY)), .BAUD_DIV(16'(BD)), .HAS_VBUS(1'b1)) i_pin_power_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n_i), .wb_i(wb_i), .wb_o(wb_o),
    .serial_out_port0_o(tx0), .serial_out_port1_o(tx1), .rts_n_o(rts_n), .cts_n_i(cts_n),
    .ri_n_i(ri_n), .dcd_n_i(dcd_n), .dsr0_n_i(dsr0_n),
    .dtr0_pin_i(lvl[0]), .dtr0_pin_o(pin_o[0]), .dtr0_pin_oe_o(pin_oe[0]),
    .dtr1_pin_i(lvl[1]), .dtr1_pin_o(pin_o[1]), .dtr1_pin_oe_o(pin_oe[1]),
    .dsr1_pin_i(lvl[2]), .dsr1_pin_o(pin_o[2]), .dsr1_pin_oe_o(pin_oe[2]),
    .vbus_i(vbus), .usb_suspend_req_i(sreq), .usb_config_done_i(cdone), .io_supply_low_i(io_low),
    .usb_configured_n_o(cfg_n), .usb_suspend_o(susp), .usb_phy_off_o(phy_off),
    .vbus_pulldown_en_o(pd_en), .vbus_discharge_o(disch));

  serial_peer i_serial_peer (.pd_i(pd), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .lvl_o(lvl));

  // Variant without a detect input; its vbus pin is held low on purpose
  pin_power_ctrl #(.RESET_DELAY(22'(DLY)), .BAUD_DIV(16'(BD)), .HAS_VBUS(1'b0)) i_pin_power_ctrl_nv (
    .clk_i(clk_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n_i), .wb_i('0), .wb_o(),
    .serial_out_port0_o(), .serial_out_port1_o(), .rts_n_o(), .cts_n_i(2'h3), .ri_n_i(2'h3), .dcd_n_i(2'h3),
    .dsr0_n_i(1'b1), .dtr0_pin_i(1'b1), .dtr0_pin_o(), .dtr0_pin_oe_o(), .dtr1_pin_i(1'b1), .dtr1_pin_o(),
    .dtr1_pin_oe_o(), .dsr1_pin_i(1'b1), .dsr1_pin_o(), .dsr1_pin_oe_o(), .vbus_i(1'b0),
    .usb_suspend_req_i(sreq), .usb_config_done_i(cdone), .io_supply_low_i(1'b0),
    .usb_configured_n_o(cfg_n_nv), .usb_suspend_o(susp_nv), .usb_phy_off_o(phy_off_nv),
    .vbus_pulldown_en_o(), .vbus_discharge_o());

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Classic single cycle; held until ack is sampled, bounded wait
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    for (n = 0; n < 20 && wb_o.ack !== 1'b1; n++)
      @(posedge clk_i);
    if (n == 20)
    begin
      num_errors++;
      results();
    end
    rd = wb_o.dat;
    wb_i <= '0;
  endtask

  // Reset by either source, then hold window with pins released
  task automatic do_reset(input logic [2:0] straps, input logic ext);
    pd <= straps;
    @(posedge clk_i);
    if (ext)
      ext_reset_n_i <= 1'b0;
    else
      rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    ext_reset_n_i <= 1'b1;
    #1;
    check("tx idle", {tx1, tx0}, 2'b11);
    check("rts idle", rts_n, 2'b11);
    check("pulldown", pd_en, 1'b1);
    check("cfg_n", cfg_n, 1'b1);
    bus(1'b0, pin_power_pkg::ADDR_STAT, 32'h0);
    check("hold", {rd[16], pin_oe}, 4'h8);
    repeat (DLY) @(posedge clk_i);
    bus(1'b0, pin_power_pkg::ADDR_STAT, 32'h0);
    check("hold end", rd[16], 1'b0);
  endtask

  // One frame with computed bit pattern, sampled mid-bit
  task automatic frame(input int p, input int idx, input logic [4:0] line, input logic [7:0] d);
    logic [11:0] e;
    logic [7:0] m;
    int n;
    int t;
    n = 5 + int'(line[1:0]);
    m = d & 8'((1 << n) - 1);
    e = 12'hfff;
    e[0] = 1'b0;
    for (int k = 0; k < n; k++)
      e[k + 1] = m[k];
    case (line[4:2])
      pin_power_pkg::PAR_ODD: e[n + 1] = ~^m;
      pin_power_pkg::PAR_EVEN: e[n + 1] = ^m;
      pin_power_pkg::PAR_MARK: e[n + 1] = 1'b1;
      pin_power_pkg::PAR_SPACE: e[n + 1] = 1'b0;
      default: ;
    endcase
    t = n + 2 + int'(line[4:2] != pin_power_pkg::PAR_NONE);
    bus(1'b1, p ? pin_power_pkg::ADDR_LINE1 : pin_power_pkg::ADDR_LINE0, {27'h0, line});
    bus(1'b1, p ? pin_power_pkg::ADDR_TX1 : pin_power_pkg::ADDR_TX0, {24'h0, d});
    @(posedge clk_i);
    for (int k = 0; k <= t; k++)
    begin
      #1;
      check("serial bit", p ? tx1 : tx0, k < t ? e[k] : 1'b1);
      check("tx indicator", lvl[idx], k < t);
      repeat (BD) @(posedge clk_i);
    end
  endtask

  // No straps: DTR pins keep modem function, asserted low
  task automatic s_plain();
    do_reset(3'b000, 1'b0);
    bus(1'b1, pin_power_pkg::ADDR_CTRL, 32'h1e);
    #1;
    check("rts_n", rts_n, 2'b00);
    check("dtr pins", lvl[1:0], 2'b00);
    bus(1'b0, pin_power_pkg::ADDR_CTRL, 32'h0);
    check("ctrl", rd, 32'h1e);
  endtask

  // Both ports strapped, port1 indicator on DSR
  task automatic s_strap_a();
    do_reset(3'b111, 1'b0);
    bus(1'b0, pin_power_pkg::ADDR_STAT, 32'h0);
    check("strap a", rd[12:10], 3'b111);
    {cts_n, ri_n, dcd_n, dsr0_n} <= 7'b1001110;
    bus(1'b0, pin_power_pkg::ADDR_STAT, 32'h0);
    check("modem in", rd[7:0], 8'h43);
    bus(1'b1, pin_power_pkg::ADDR_CTRL, 32'h1e);
    bus(1'b0, pin_power_pkg::ADDR_CTRL, 32'h0);
    check("ctrl dtr", rd, 32'h1c);
    for (int i = 0; i < 5; i++)
      frame(0, 0, {3'(i), 2'(i)}, 8'hb5 + 8'(i));
    frame(1, 2, 5'h03, 8'h3c);
    pd <= 3'b000;
    bus(1'b0, pin_power_pkg::ADDR_STAT, 32'h0);
    check("latched", rd[12:10], 3'b111);
  endtask

  // External reset; port1 indicator on DTR
  task automatic s_strap_b();
    do_reset(3'b011, 1'b1);
    bus(1'b0, pin_power_pkg::ADDR_STAT, 32'h0);
    check("strap b", rd[12:10], 3'b011);
    frame(1, 1, 5'h0b, 8'h96);
    // Both DTR pins reassigned, so neither DTR bit reads back
    bus(1'b1, pin_power_pkg::ADDR_CTRL, 32'h06);
    bus(1'b0, pin_power_pkg::ADDR_CTRL, 32'h0);
    check("ctrl dtr b", rd, 32'h0);
  endtask

  // Suspend, bus power loss and low-supply discharge
  task automatic s_power();
    #1;
    check("configured", cfg_n, 1'b0);
    check("nv configured", cfg_n_nv, 1'b0);
    @(posedge clk_i);
    sreq <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check("suspend", {susp, cfg_n}, 2'b11);
    @(posedge clk_i);
    sreq <= 1'b0;
    vbus <= 1'b0;
    #1;
    check("phy off", phy_off, 1'b1);
    repeat (3) @(posedge clk_i);
    #1;
    check("vbus susp", susp, 1'b1);
    check("nv no vbus", {susp_nv, phy_off_nv, cfg_n_nv}, 3'b000);
    @(posedge clk_i);
    vbus <= 1'b1;
    bus(1'b1, pin_power_pkg::ADDR_CTRL, 32'h01);
    #1;
    check("pd off", pd_en, 1'b0);
    @(posedge clk_i);
    io_low <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check("discharge", disch, 1'b1);
    @(posedge clk_i);
    io_low <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check("recover", {disch, pd_en, susp}, 3'b010);
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial
  begin
    {rst_i, ext_reset_n_i, dsr0_n, vbus, sreq, cdone, io_low} = 7'b1111010;
    {cts_n, ri_n, dcd_n, pd} = 9'h1f8;
    wb_i = '0;
    s_plain();
    s_strap_a();
    s_strap_b();
    s_power();
    results();
  end
endmodule
